// ---- tb_uart_fifo_interrupt_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_interrupt_control;
    import ufi_pkg::*;
    logic       clk_i, rst_b_i, cs_b, rd_b, wr_b, rx_valid, tick, tx_ready;
    logic       data_oe, rx_ready, tx_valid, intr, rx_dma_b, tx_dma_b;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rx_data, tx_data, q;
    logic [3:0] err, delta;
    int         miscompares = 0, check_count = 0, lvl, k, lv[4] = '{1, 4, 8, 14};
    logic [7:0] rxq[$];
    ufi_host i_host (.clk_i(clk_i), .data_o(rdata), .cs_b_o(cs_b), .rd_b_o(rd_b),
        .wr_b_o(wr_b), .addr_o(addr), .wdata_o(wdata));
    ufi_ctrl i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .rd_b_i(rd_b),
        .wr_b_i(wr_b), .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe),
        .dlab_i(1'b0), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
        .line_err_i(err), .char_tick_i(tick), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_ready_i(tx_ready), .tsr_empty_i(1'b1), .ms_delta_i(delta), .ms_lines_i(4'h0),
        .interrupt_output_o(intr), .receive_ready_out_b_o(rx_dma_b),
        .transmit_ready_out_b_o(tx_dma_b));
    // Free-running 250 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk1
    // Expected low line status bits for one error flag.
    function automatic logic [7:0] lsr_exp(input int e);
        return 8'h01 | (8'h02 << e);
    endfunction : lsr_exp
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_host.cyc(a, d, 1'b1, x);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        i_host.cyc(a, 8'h00, 1'b0, d);
    endtask : rd
    // Checks the interrupt line against the expected code, then reads the code.
    task automatic id(input logic [7:0] e);
        logic [7:0] r;
        repeat (4) @(negedge clk_i);
        chk1(intr, !e[0]);
        rd(ADDR_IDFC, r);
        chk8(r, e);
    endtask : id
    // Offers one character from the receiver and records it.
    task automatic push(input logic [7:0] d);
        int n;
        @(negedge clk_i);
        rx_data = d;
        rx_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rx_ready !== 1'b1 && n < 50);
        if (n == 50) begin
            miscompares++;
            end_sim();
        end
        rxq.push_back(d);
        @(negedge clk_i);
        rx_valid = 1'b0;
    endtask : push
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk_i) tick = 1'b1;
            @(negedge clk_i) tick = 1'b0;
        end
    endtask : ticks
    task automatic pop_chk;
        rd(ADDR_DATA, q);
        chk8(q, rxq.pop_front());
    endtask : pop_chk
    initial begin
        rst_b_i = 1'b0;
        {rx_valid, tick, tx_ready, err, delta, rx_data} = '0;
        void'($urandom(8064));
        repeat (20) @(negedge clk_i);
        rst_b_i = 1'b1;
        id(8'h01);
        wr(ADDR_IEN, 8'hF1);
        rd(ADDR_IEN, q);
        chk8(q, 8'h01);
        // Every trigger level; time-out and restart around it at levels 4, 8 and 14 only.
        for (int t = 0; t < 4; t++) begin
            lvl = lv[t];
            wr(ADDR_IDFC, {t[1:0], 6'h03});
            rxq.delete();
            if (lvl > 1) begin
                repeat (lvl - 2) push(8'($urandom));
                ticks(3);
                push(8'($urandom));
                ticks(4);
                id(8'hC1);
                ticks(1);
                id(8'hCC);
                pop_chk();
                id(8'hC1);
            end
            while (rxq.size() < lvl - 1) push(8'($urandom));
            id(8'hC1);
            push(8'($urandom));
            id(8'hC4);
            pop_chk();
            id(8'hC1);
            wr(ADDR_IDFC, {t[1:0], 6'h03});
            rd(ADDR_LSTS, q);
            chk1(q[0], 1'b0);
        end
        // Line status outranks data available.
        wr(ADDR_IEN, 8'h05);
        wr(ADDR_IDFC, 8'h09);
        rxq.delete();
        push(8'($urandom));
        k = $urandom_range(3, 0);
        @(negedge clk_i) err[k] = 1'b1;
        @(negedge clk_i) err = 4'h0;
        chk1(rx_dma_b, 1'b0);
        id(8'hC6);
        rd(ADDR_LSTS, q);
        chk8({3'h0, q[4:0]}, lsr_exp(k));
        id(8'hC4);
        pop_chk();
        id(8'hC1);
        // Transmit-empty after enable changes, after two bytes, and after one.
        wr(ADDR_IEN, 8'h02);
        wr(ADDR_IDFC, 8'h00);
        id(8'h02);
        wr(ADDR_IDFC, 8'h01);
        id(8'hC2);
        id(8'hC1);
        wr(ADDR_DATA, 8'h3C);
        wr(ADDR_DATA, 8'hC3);
        chk8(tx_data, 8'h3C);
        chk1(tx_dma_b, 1'b1);
        wr(ADDR_IDFC, 8'h09);
        id(8'hC1);
        chk1(tx_dma_b, 1'b0);
        @(negedge clk_i) tx_ready = 1'b1;
        repeat (3) @(negedge clk_i);
        tx_ready = 1'b0;
        id(8'hC2);
        wr(ADDR_DATA, 8'($urandom));
        @(negedge clk_i) tx_ready = 1'b1;
        repeat (3) @(negedge clk_i);
        tx_ready = 1'b0;
        id(8'hC1);
        ticks(1);
        id(8'hC2);
        wr(ADDR_DATA, 8'h5A);
        wr(ADDR_IDFC, 8'h05);
        chk1(tx_valid, 1'b0);
        // Modem change, lowest level, cleared by its status read.
        wr(ADDR_IEN, 8'h08);
        @(negedge clk_i) delta[$urandom_range(3, 0)] = 1'b1;
        @(negedge clk_i) delta = 4'h0;
        id(8'hC0);
        rd(ADDR_MSTS, q);
        id(8'hC1);
        end_sim();
    end
endmodule : tb_uart_fifo_interrupt_control
`default_nettype wire

// ---- ufi_ctrl.sv ----
// Notes on behaviour
// - Control writes and identification reads share one address.
// - Bit 0 enables FIFOs, gates other bits, and any change flushes both.
// - Bit 1 flushes the receive FIFO only; it never stores.
// - Bit 2 flushes the transmit FIFO only; it never stores.
// - Bit 3 selects DMA signalling mode 1 while FIFOs are enabled.
// - Bits 7:6 pick trigger 1, 4, 8 or 14; bits 5:4 reserved.
// - Data-available and its code follow fill against trigger level.
// - Line status code 06 outranks data-available code 04.
// - Data ready reads one while the receive FIFO holds anything.
// - Time-out when data waits over four character times without traffic.
// - Time-out counts character ticks from the receive clock logic.
// - A data read clears an active time-out and its timer.
// - Without time-out, a new character or a read restarts the timer.
// - Transmit-empty raised on empty FIFO; cleared by data write or an ID read returning code 02.
// - In FIFO mode, transmit-empty delayed one character unless two bytes were queued.
// - Cleared enables give polled mode; FIFOs keep buffering.
// - Enable bits 0 to 3 gate four sources; bits 7:4 read zero.
// - Priority: line status, data or time-out, transmit empty, modem.
// - ID bit 0 low while pending; bits 2:1 give top source.
// - ID bit 3 marks time-out in FIFO mode, zero otherwise.
// - ID bits 7:6 copy FIFO enable; bits 5:4 read zero.
// - Modem changes raise lowest priority, cleared by modem status read.
// - Line status read clears errors; data read clears time-out, and data-available once fill drops below trigger.
// - Overrun, parity, framing or break raises line status interrupt.
`timescale 1ns/1ps
`default_nettype none
module ufi_ctrl #(
    parameter int DEPTH = ufi_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Host register bus pins.
    input  wire logic       cs_b_i,
    input  wire logic       rd_b_i,
    input  wire logic       wr_b_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] data_i,
    output var  logic [7:0] data_o,
    output var  logic       data_oe_o,
    // Divisor latch access bit from line control.
    input  wire logic       dlab_i,
    // Receiver side.
    input  wire logic       rx_valid_i,
    input  wire logic [7:0] rx_data_i,
    output var  logic       rx_ready_o,
    input  wire logic [3:0] line_err_i,
    input  wire logic       char_tick_i,
    // Transmitter side.
    output var  logic       tx_valid_o,
    output var  logic [7:0] tx_data_o,
    input  wire logic       tx_ready_i,
    input  wire logic       tsr_empty_i,
    // Modem status inputs.
    input  wire logic [3:0] ms_delta_i,
    input  wire logic [3:0] ms_lines_i,
    // Interrupt and DMA signalling.
    output var  logic       interrupt_output_o,
    output var  logic       receive_ready_out_b_o,
    output var  logic       transmit_ready_out_b_o
);
    import ufi_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    ufi_fifo_if #(.W(8), .D(DEPTH)) rxf ();
    ufi_fifo_if #(.W(8), .D(DEPTH)) txf ();

    logic [13:0] sync1_q, sync2_q;
    logic        rd_prev_q, wr_prev_q;
    logic [2:0]  rd_addr_q, wr_addr_q;
    logic [7:0]  wr_data_q;
    logic        rd_dlab_q;
    logic [3:0]  rd_id_q;
    logic        fifo_en_q, dma_mode_q;
    logic [1:0]  trig_q;
    logic [3:0]  ien_q;
    logic [3:0]  err_q, delta_q;
    logic        tout_q;
    logic [2:0]  tcnt_q;
    logic        transmit_holding_empty_q, arm_q, two_q, first_q, tx_empty_prev_q;
    logic        rx_dma_act_q;

    logic       cs_s, rd_s, wr_s, dlab_s;
    logic [2:0] addr_s;
    logic [7:0] din_s;
    logic       rd_act, wr_act, rd_start, rd_end, wr_end;
    logic       fc_wr, rbr_pop, thr_push, lsr_rd, msr_rd, iir_rd;
    logic       toggle, rx_flush, tx_flush;
    logic       rx_any, tx_empty, trig_hit;
    logic       ls_int, rd_int, to_int, th_int, ms_int;
    logic [3:0] id_now;
    logic [7:0] lsr_val, iir_val, rd_val;

    // Byte count selected by the trigger field.
    function automatic logic [CW-1:0] trig_bytes(input logic [1:0] sel);
        logic [4:0] b;
        b = TRIG_L0;
        unique case (sel)
            2'h0: b = TRIG_L0;
            2'h1: b = TRIG_L1;
            2'h2: b = TRIG_L2;
            2'h3: b = TRIG_L3;
        endcase
        return CW'(b);
    endfunction : trig_bytes

    // Bus pins pass two flip-flops before use.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_q <= 14'h3FFF;
            sync2_q <= 14'h3FFF;
        end else begin
            sync1_q <= {cs_b_i, rd_b_i, wr_b_i, addr_i, data_i};
            sync2_q <= sync1_q;
        end
    end

    assign cs_s   = ~sync2_q[13];
    assign rd_s   = ~sync2_q[12];
    assign wr_s   = ~sync2_q[11];
    assign addr_s = sync2_q[10:8];
    assign din_s  = sync2_q[7:0];
    assign dlab_s = dlab_i;

    // Access phases: read data is taken at the start, side effects at the end.
    assign rd_act   = cs_s & rd_s;
    assign wr_act   = cs_s & wr_s;
    assign rd_start = rd_act & ~rd_prev_q;
    assign rd_end   = ~rd_act & rd_prev_q;
    assign wr_end   = ~wr_act & wr_prev_q;

    // Decoded strobes for each register effect.
    assign fc_wr    = wr_end & (wr_addr_q == ADDR_IDFC) & ~dlab_s;
    assign thr_push = wr_end & (wr_addr_q == ADDR_DATA) & ~dlab_s;
    assign rbr_pop  = rd_end & (rd_addr_q == ADDR_DATA) & ~rd_dlab_q & rxf.out_valid;
    assign iir_rd   = rd_end & (rd_addr_q == ADDR_IDFC) & ~rd_dlab_q;
    assign lsr_rd   = rd_end & (rd_addr_q == ADDR_LSTS);
    assign msr_rd   = rd_end & (rd_addr_q == ADDR_MSTS);

    // Latch address and data of the access in progress.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
            rd_addr_q <= 3'h0;
            wr_addr_q <= 3'h0;
            wr_data_q <= 8'h00;
            rd_dlab_q <= 1'b0;
            rd_id_q   <= ID_NONE;
        end else begin
            rd_prev_q <= rd_act;
            wr_prev_q <= wr_act;
            if (wr_act) begin
                wr_addr_q <= addr_s;
                wr_data_q <= din_s;
            end
            if (rd_start) begin
                rd_addr_q <= addr_s;
                rd_dlab_q <= dlab_s;
                rd_id_q   <= id_now;
            end
        end
    end

    // Enable changes flush both queues; bits 1 and 2 act as pulses.
    assign toggle   = fc_wr & (wr_data_q[FC_EN] != fifo_en_q);
    assign rx_flush = toggle | (fc_wr & wr_data_q[FC_EN] & wr_data_q[FC_RXCLR]);
    assign tx_flush = toggle | (fc_wr & wr_data_q[FC_EN] & wr_data_q[FC_TXCLR]);

    // FIFO control fields take effect only with bit 0 written as one.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fifo_en_q  <= 1'b0;
            dma_mode_q <= 1'b0;
            trig_q     <= TRIG_RST;
        end else if (fc_wr) begin
            fifo_en_q <= wr_data_q[FC_EN];
            if (wr_data_q[FC_EN]) begin
                dma_mode_q <= wr_data_q[FC_DMA];
                trig_q     <= wr_data_q[FC_TRIG +: 2];
            end
        end
    end

    // Interrupt enable register; upper bits are not stored.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ien_q <= IEN_RST;
        end else if (wr_end && wr_addr_q == ADDR_IEN && !dlab_s) begin
            ien_q <= wr_data_q[3:0];
        end
    end

    // Receive queue; without FIFOs it holds a single character.
    assign rxf.in_valid  = rx_valid_i & (fifo_en_q | (rxf.count == '0));
    assign rxf.in_data   = rx_data_i;
    assign rxf.out_ready = rbr_pop;
    assign rxf.flush     = rx_flush;
    assign rx_ready_o    = rxf.in_ready;

    ufi_fifo #(.W(8), .D(DEPTH)) u_rx_fifo (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .f       (rxf)
    );

    // Transmit queue; without FIFOs it holds a single character.
    assign txf.in_valid  = thr_push & (fifo_en_q | (txf.count == '0));
    assign txf.in_data   = wr_data_q;
    assign txf.out_ready = tx_ready_i;
    assign txf.flush     = tx_flush;
    assign tx_valid_o    = txf.out_valid;
    assign tx_data_o     = txf.out_data;

    ufi_fifo #(.W(8), .D(DEPTH)) u_tx_fifo (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .f       (txf)
    );

    // Fill level conditions.
    assign rx_any   = (rxf.count != '0);
    assign tx_empty = (txf.count == '0);
    assign trig_hit = fifo_en_q ? (rxf.count >= trig_bytes(trig_q)) : rx_any;

    // Sticky line errors; a new error wins over a same-cycle read.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            err_q <= 4'h0;
        end else begin
            err_q <= (lsr_rd ? 4'h0 : err_q) | line_err_i;
        end
    end

    // Sticky modem deltas cleared by a modem status read.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            delta_q <= 4'h0;
        end else begin
            delta_q <= (msr_rd ? 4'h0 : delta_q) | ms_delta_i;
        end
    end

    // Time-out timer counts character ticks since the last push or pop.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tcnt_q <= 3'h0;
            tout_q <= 1'b0;
        end else if (!rx_any || rx_flush) begin
            tcnt_q <= 3'h0;
            tout_q <= 1'b0;
        end else if (rbr_pop || (rxf.in_valid && rxf.in_ready)) begin
            tcnt_q <= 3'h0;
            tout_q <= 1'b0;
        end else if (char_tick_i && !tout_q) begin
            // The first tick may close a partial character, so one extra is needed.
            if (tcnt_q == TOUT_CHARS) begin
                tout_q <= 1'b1;
            end else begin
                tcnt_q <= tcnt_q + 3'h1;
            end
        end
    end

    // Transmit-empty source with its optional one-character delay.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            transmit_holding_empty_q          <= 1'b0;
            arm_q           <= 1'b0;
            two_q           <= 1'b0;
            first_q         <= 1'b1;
            tx_empty_prev_q <= 1'b1;
        end else begin
            tx_empty_prev_q <= tx_empty;
            if (txf.count >= CW'(2)) begin
                two_q <= 1'b1;
            end else if (tx_empty && !tx_empty_prev_q) begin
                two_q <= 1'b0;
            end
            if (toggle) begin
                first_q <= 1'b1;
            end else if (transmit_holding_empty_q) begin
                first_q <= 1'b0;
            end
            if (tx_empty && !tx_empty_prev_q && fifo_en_q && !two_q && !first_q) begin
                arm_q <= 1'b1;
            end else if (!tx_empty || transmit_holding_empty_q) begin
                arm_q <= 1'b0;
            end
            if (tx_empty && ((!tx_empty_prev_q && (!fifo_en_q || two_q))
                    || first_q || (arm_q && char_tick_i))) begin
                transmit_holding_empty_q <= 1'b1;
            end else if (thr_push || (iir_rd && rd_id_q == ID_THE)) begin
                transmit_holding_empty_q <= 1'b0;
            end
        end
    end

    // Enabled sources; cleared enables leave the queues running.
    assign ls_int = ien_q[IE_RLS] & (err_q != 4'h0);
    assign rd_int = ien_q[IE_RDA] & trig_hit;
    assign to_int = ien_q[IE_RDA] & fifo_en_q & tout_q;
    assign th_int = ien_q[IE_THE] & transmit_holding_empty_q;
    assign ms_int = ien_q[IE_MS] & (delta_q != 4'h0);

    // Highest pending source wins the identification code.
    always_comb begin
        if (ls_int) begin
            id_now = ID_RLS;
        end else if (rd_int) begin
            id_now = ID_RDA;
        end else if (to_int) begin
            id_now = ID_TOUT;
        end else if (th_int) begin
            id_now = ID_THE;
        end else if (ms_int) begin
            id_now = ID_MS;
        end else begin
            id_now = ID_NONE;
        end
    end

    // Identification and line status read values.
    assign iir_val = {{2{fifo_en_q}}, 2'b00, id_now};
    assign lsr_val = {fifo_en_q & (err_q[3:1] != 3'h0), tx_empty & tsr_empty_i,
                      tx_empty, err_q, rx_any};

    // Read multiplexer at the start of a read.
    always_comb begin
        unique case (addr_s)
            ADDR_DATA: rd_val = dlab_s ? 8'h00 : rxf.out_data;
            ADDR_IEN:  rd_val = dlab_s ? 8'h00 : {4'h0, ien_q};
            ADDR_IDFC: rd_val = dlab_s ? 8'h00 : iir_val;
            ADDR_LSTS: rd_val = lsr_val;
            ADDR_MSTS: rd_val = {ms_lines_i, delta_q};
            default:   rd_val = 8'h00;
        endcase
    end

    // Data bus drive follows the synchronised read strobe.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= rd_act;
            if (rd_start) begin
                data_o <= rd_val;
            end
        end
    end

    // Interrupt line is high whenever any enabled source is pending.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            interrupt_output_o <= 1'b0;
        end else begin
            interrupt_output_o <= ls_int | rd_int | to_int | th_int | ms_int;
        end
    end

    // Mode 1 receive request holds from trigger or time-out until empty.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_dma_act_q <= 1'b0;
        end else if (!rx_any) begin
            rx_dma_act_q <= 1'b0;
        end else if (trig_hit || tout_q) begin
            rx_dma_act_q <= 1'b1;
        end
    end

    // DMA outputs are active low; mode 1 needs FIFOs enabled.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            receive_ready_out_b_o  <= 1'b1;
            transmit_ready_out_b_o <= 1'b0;
        end else if (fifo_en_q && dma_mode_q) begin
            receive_ready_out_b_o  <= ~rx_dma_act_q;
            transmit_ready_out_b_o <= ~txf.in_ready;
        end else begin
            receive_ready_out_b_o  <= ~rx_any;
            transmit_ready_out_b_o <= ~tx_empty;
        end
    end

endmodule : ufi_ctrl
`default_nettype wire

// ---- ufi_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufi_chk (
    // Clock, reset and bus pins.
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic       cs_b_i,
    input wire logic       rd_b_i,
    input wire logic [2:0] addr_i,
    input wire logic       dlab_i,
    // Watched results.
    input wire logic [7:0] data_o,
    input wire logic       data_oe_o,
    input wire logic       tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic       tx_ready_i
);
    import ufi_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // The identification register sits behind the shared control address.
    logic id_at;
    assign id_at = !dlab_i && addr_i == ADDR_IDFC;
    a_id_fixed_bits: assert property ($rose(data_oe_o) && id_at |->
        data_o[5:4] == 2'h0 && data_o[7] == data_o[6]) else $error("id fixed bits wrong");
    a_id_none_code: assert property ($rose(data_oe_o) && id_at && data_o[0] |->
        data_o[3:1] == 3'h0) else $error("id idle code wrong");
    a_id_tout_code: assert property ($rose(data_oe_o) && id_at && data_o[3] |->
        data_o[2:1] == 2'h2 && data_o[7:6] == 2'h3) else $error("id time-out code wrong");
    a_ien_high_zero: assert property ($rose(data_oe_o) && !dlab_i && addr_i == ADDR_IEN |->
        data_o[7:4] == 4'h0) else $error("enable high bits set");
    a_rd_answer_time: assert property ($fell(rd_b_i) && !cs_b_i |-> ##[2:4] data_oe_o)
        else $error("read answer late");
    a_rd_answer_holds: assert property (data_oe_o && !rd_b_i && !cs_b_i |=>
        data_oe_o && $stable(data_o)) else $error("read answer moved");
    a_rd_release_time: assert property ($rose(rd_b_i) |-> ##[2:4] !data_oe_o)
        else $error("read answer not released");
    a_tx_head_holds: assert property (tx_valid_o && !tx_ready_i |=>
        !tx_valid_o || $stable(tx_data_o)) else $error("transmit head changed");
endmodule : ufi_chk
bind ufi_ctrl ufi_chk i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
    .rd_b_i(rd_b_i), .addr_i(addr_i), .dlab_i(dlab_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i));
`default_nettype wire

// ---- ufi_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufi_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Queue ports.
    ufi_fifo_if.fifo f
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_q, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          push, pop;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction : nxt

    // Accepted transfers on each side.
    assign push = f.in_valid & f.in_ready;
    assign pop  = f.out_valid & f.out_ready;
    assign rd_d = pop ? nxt(rd_q) : rd_q;

    // Next fill count.
    always_comb begin
        cnt_d = cnt_q;
        if (push & ~pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Storage is written only on an accepted push.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_q] <= f.in_data;
        end
    end

    // Pointers, count and registered flags; flush empties everything.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q        <= '0;
            rd_q        <= '0;
            cnt_q       <= '0;
            f.in_ready  <= 1'b0;
            f.out_valid <= 1'b0;
        end else if (f.flush) begin
            wr_q        <= '0;
            rd_q        <= '0;
            cnt_q       <= '0;
            f.in_ready  <= 1'b1;
            f.out_valid <= 1'b0;
        end else begin
            wr_q        <= push ? nxt(wr_q) : wr_q;
            rd_q        <= rd_d;
            cnt_q       <= cnt_d;
            f.in_ready  <= (cnt_d != CW'(D));
            f.out_valid <= (cnt_d != '0);
        end
    end

    // Head word is registered; a push into an empty head bypasses memory.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            f.out_data <= '0;
        end else if (push && wr_q == rd_d) begin
            f.out_data <= f.in_data;
        end else begin
            f.out_data <= mem[rd_d];
        end
    end

    assign f.count = cnt_q;

endmodule : ufi_fifo
`default_nettype wire

// ---- ufi_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ufi_fifo_if #(
    parameter int W = 8,
    parameter int D = 16
);
    localparam int CW = $clog2(D + 1);
    logic          in_valid;
    logic          in_ready;
    logic [W-1:0]  in_data;
    logic          out_valid;
    logic          out_ready;
    logic [W-1:0]  out_data;
    logic          flush;
    logic [CW-1:0] count;

    modport fifo (input in_valid, in_data, out_ready, flush,
                  output in_ready, out_valid, out_data, count);
    modport user (output in_valid, in_data, out_ready, flush,
                  input in_ready, out_valid, out_data, count);
endinterface : ufi_fifo_if
`default_nettype wire

// ---- ufi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufi_host (
    // Clock and read data.
    input  wire logic       clk_i,
    input  wire logic [7:0] data_o,
    // Bus pins towards the channel.
    output var  logic       cs_b_o,
    output var  logic       rd_b_o,
    output var  logic       wr_b_o,
    output var  logic [2:0] addr_o,
    output var  logic [7:0] wdata_o
);
    // Idle bus: strobes high, data lines showing a changing pattern.
    initial begin
        cs_b_o = 1'b1;
        rd_b_o = 1'b1;
        wr_b_o = 1'b1;
        addr_o = 3'h0;
        wdata_o = 8'hA5;
    end
    // One cycle: strobe low five clocks, answer taken at the last rising edge.
    task automatic cyc(input logic [2:0] a, input logic [7:0] d, input logic w,
                       output logic [7:0] q);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = w ? d : ~wdata_o;
        cs_b_o = 1'b0;
        if (w) wr_b_o = 1'b0;
        else rd_b_o = 1'b0;
        repeat (5) @(posedge clk_i);
        q = data_o;
        @(negedge clk_i);
        cs_b_o = 1'b1;
        rd_b_o = 1'b1;
        wr_b_o = 1'b1;
        repeat (3) @(negedge clk_i);
        wdata_o = ~wdata_o;
    endtask : cyc
endmodule : ufi_host
`default_nettype wire

// ---- ufi_pkg.sv ----
package ufi_pkg;

    // Register offsets on the three-bit address port.
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IEN  = 3'h1;
    localparam logic [2:0] ADDR_IDFC = 3'h2;
    localparam logic [2:0] ADDR_LSTS = 3'h5;
    localparam logic [2:0] ADDR_MSTS = 3'h6;

    // FIFO control fields.
    localparam int FC_EN    = 0;
    localparam int FC_RXCLR = 1;
    localparam int FC_TXCLR = 2;
    localparam int FC_DMA   = 3;
    localparam int FC_TRIG  = 6;

    // Interrupt enable fields.
    localparam int IE_RDA = 0;
    localparam int IE_THE = 1;
    localparam int IE_RLS = 2;
    localparam int IE_MS  = 3;

    // Reset values.
    localparam logic [3:0] IEN_RST  = 4'h0;
    localparam logic [1:0] TRIG_RST = 2'h0;

    // Identification codes in bits 3:0.
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_RLS  = 4'h6;
    localparam logic [3:0] ID_RDA  = 4'h4;
    localparam logic [3:0] ID_TOUT = 4'hC;
    localparam logic [3:0] ID_THE  = 4'h2;
    localparam logic [3:0] ID_MS   = 4'h0;

    // Receive trigger levels in bytes.
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0E;

    // Time-out length in character times, and the FIFO depth.
    localparam logic [2:0] TOUT_CHARS = 3'h4;
    localparam int         FIFO_DEPTH = 16;

endpackage : ufi_pkg
